// [tclko_consts.svh]
// constants for the timer clock-out block: offsets, bit positions, resets, timing
// assumes inclusion by the timer module and package users only
`ifndef TCLKO_CONSTS_SVH
`define TCLKO_CONSTS_SVH
`define TCLKO_OFF_CONTROL 8'hC8
`define TCLKO_OFF_MODE 8'hC9
`define TCLKO_OFF_RELOAD_LOW 8'hCA
`define TCLKO_OFF_RELOAD_HIGH 8'hCB
`define TCLKO_OFF_COUNT_LOW 8'hCC
`define TCLKO_OFF_COUNT_HIGH 8'hCD
`define TCLKO_OFF_BITSET 8'hD0
`define TCLKO_OFF_BITCLR 8'hD4
`define TCLKO_BIT_OVF 7
`define TCLKO_BIT_EXF 6
`define TCLKO_BIT_RXSEL 5
`define TCLKO_BIT_TXSEL 4
`define TCLKO_BIT_EXEN 3
`define TCLKO_BIT_RUN 2
`define TCLKO_BIT_CSRC 1
`define TCLKO_BIT_CPRL 0
`define TCLKO_BIT_CLKOE 1
`define TCLKO_BIT_DCEN 0
`define TCLKO_RST_BYTE 8'h00
`define TCLKO_RST_COUNT 16'h0000
`define TCLKO_OSC_DIV 2
`endif

// [tclko_pkg.sv]
// types for the timer clock-out block
// assumes tclko_consts.svh supplies the numbers
package tclko_pkg;
    typedef enum logic [1:0] {
        TCLKO_SRC_STOP,
        TCLKO_SRC_OSC,
        TCLKO_SRC_PIN
    } tclko_src_t;
endpackage

// [tclko_timer.sv]
// 16-bit timer with clock-out, reload/capture and control register, AHB-Lite slave
// assumes a single AHB-Lite master, word transfers; pins from outside are synchronised here
`timescale 1ns/1ps
`include "tclko_consts.svh"

module tclko_timer (
    // bus clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pins
    input wire logic count_in_clock_out_pin_in,
    output logic count_in_clock_out_pin_out,
    output logic count_in_clock_out_pin_oe_n,
    input wire logic external_trigger_pin,
    // serial port and interrupt side
    input wire logic timer1_overflow,
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    output logic timer_irq
);
    logic [7:0] control_reg;
    logic [1:0] mode_reg;
    logic [15:0] count_reg;
    logic [15:0] reload_reg;
    logic clk_out_reg;
    logic div_reg;
    logic [2:0] pin_sync_reg;
    logic [2:0] trig_sync_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_next;
    tclko_pkg::tclko_src_t src;
    logic tick, ovf, trig_fall, baud_mode, cap_mode;
    logic wr_ctl, wr_set, wr_clr;
    logic [7:0] ctl_wdata;

    // one decode for every register write strobe
    function automatic logic wr_hit(input logic pend, input logic [7:0] addr, input logic [7:0] off);
        return pend && (addr == off);
    endfunction

    // address phase captured; writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // read data registered so hrdata comes from a flip-flop; zero wait states
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (haddr[7:0])
            `TCLKO_OFF_CONTROL: rdata_next = {24'h000000, control_reg};
            `TCLKO_OFF_MODE: rdata_next = {30'h0000_0000, mode_reg};
            `TCLKO_OFF_RELOAD_LOW: rdata_next = {24'h000000, reload_reg[7:0]};
            `TCLKO_OFF_RELOAD_HIGH: rdata_next = {24'h000000, reload_reg[15:8]};
            `TCLKO_OFF_COUNT_LOW: rdata_next = {24'h000000, count_reg[7:0]};
            `TCLKO_OFF_COUNT_HIGH: rdata_next = {24'h000000, count_reg[15:8]};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                hrdata <= rdata_next;
            end
        end
    end

    // pins are asynchronous: two flops before any logic, third for edge detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sync_reg <= 3'b000;
            trig_sync_reg <= 3'b111;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], count_in_clock_out_pin_in};
            trig_sync_reg <= {trig_sync_reg[1:0], external_trigger_pin};
        end
    end

    // oscillator divided by two
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign wr_ctl = wr_hit(wr_pend_reg, wr_addr_reg, `TCLKO_OFF_CONTROL);
    assign wr_set = wr_hit(wr_pend_reg, wr_addr_reg, `TCLKO_OFF_BITSET);
    assign wr_clr = wr_hit(wr_pend_reg, wr_addr_reg, `TCLKO_OFF_BITCLR);
    assign baud_mode = control_reg[`TCLKO_BIT_RXSEL] || control_reg[`TCLKO_BIT_TXSEL];
    // capture only without baud mode and without clock-out
    assign cap_mode = control_reg[`TCLKO_BIT_CPRL] && !baud_mode && !mode_reg[`TCLKO_BIT_CLKOE];
    assign trig_fall = control_reg[`TCLKO_BIT_EXEN] && trig_sync_reg[2] && !trig_sync_reg[1];

    always_comb begin
        if (!control_reg[`TCLKO_BIT_RUN]) begin
            src = tclko_pkg::TCLKO_SRC_STOP;
        end else if (control_reg[`TCLKO_BIT_CSRC] && !mode_reg[`TCLKO_BIT_CLKOE]) begin
            src = tclko_pkg::TCLKO_SRC_PIN;
        end else begin
            src = tclko_pkg::TCLKO_SRC_OSC;
        end
    end

    always_comb begin
        case (src)
            tclko_pkg::TCLKO_SRC_OSC: tick = div_reg;
            tclko_pkg::TCLKO_SRC_PIN: tick = pin_sync_reg[2] && !pin_sync_reg[1];
            default: tick = 1'b0;
        endcase
    end

    assign ovf = tick && (count_reg == 16'hFFFF);

    // byte-wide write or per-bit set/clear; hardware sets win over clears
    always_comb begin
        ctl_wdata = control_reg;
        if (wr_ctl) begin
            ctl_wdata = hwdata[7:0];
        end else if (wr_set) begin
            ctl_wdata = control_reg | hwdata[7:0];
        end else if (wr_clr) begin
            ctl_wdata = control_reg & ~hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= `TCLKO_RST_BYTE;
        end else begin
            control_reg <= ctl_wdata;
            if (ovf && !baud_mode) begin
                control_reg[`TCLKO_BIT_OVF] <= 1'b1;
            end
            if (trig_fall) begin
                control_reg[`TCLKO_BIT_EXF] <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= 2'b00;
        end else if (wr_hit(wr_pend_reg, wr_addr_reg, `TCLKO_OFF_MODE)) begin
            mode_reg <= hwdata[1:0];
        end
    end

    // reload pair shared by baud and clock-out; capture writes it from count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_reg <= `TCLKO_RST_COUNT;
        end else if (cap_mode && trig_fall) begin
            reload_reg <= count_reg;
        end else if (wr_hit(wr_pend_reg, wr_addr_reg, `TCLKO_OFF_RELOAD_LOW)) begin
            reload_reg[7:0] <= hwdata[7:0];
        end else if (wr_hit(wr_pend_reg, wr_addr_reg, `TCLKO_OFF_RELOAD_HIGH)) begin
            reload_reg[15:8] <= hwdata[7:0];
        end
    end

    // overflow reload also restarts from reload after an odd start count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= `TCLKO_RST_COUNT;
        end else if (ovf && !cap_mode) begin
            count_reg <= reload_reg;
        end else if (trig_fall && !cap_mode) begin
            count_reg <= reload_reg;
        end else if (wr_hit(wr_pend_reg, wr_addr_reg, `TCLKO_OFF_COUNT_LOW)) begin
            count_reg[7:0] <= hwdata[7:0];
        end else if (wr_hit(wr_pend_reg, wr_addr_reg, `TCLKO_OFF_COUNT_HIGH)) begin
            count_reg[15:8] <= hwdata[7:0];
        end else if (tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // toggle per overflow gives 50% duty and the factor four
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_out_reg <= 1'b0;
            count_in_clock_out_pin_out <= 1'b0;
            count_in_clock_out_pin_oe_n <= 1'b1;
        end else begin
            if (ovf && mode_reg[`TCLKO_BIT_CLKOE]) begin
                clk_out_reg <= !clk_out_reg;
            end
            count_in_clock_out_pin_out <= clk_out_reg;
            count_in_clock_out_pin_oe_n <= !mode_reg[`TCLKO_BIT_CLKOE];
        end
    end

    // serial clocks and interrupt; clock-out overflows flag nothing in baud mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
            timer_irq <= 1'b0;
        end else begin
            rx_baud_tick <= control_reg[`TCLKO_BIT_RXSEL] ? ovf : timer1_overflow;
            tx_baud_tick <= control_reg[`TCLKO_BIT_TXSEL] ? ovf : timer1_overflow;
            // overflow flag still visible in clock-out, but it must not interrupt there
            timer_irq <= (control_reg[`TCLKO_BIT_OVF] && !mode_reg[`TCLKO_BIT_CLKOE])
                || control_reg[`TCLKO_BIT_EXF];
        end
    end

    a_ovf_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (ovf && !baud_mode) |=> control_reg[`TCLKO_BIT_OVF])
        else $error("overflow did not set flag");
    a_baud_no_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (baud_mode && !$past(control_reg[`TCLKO_BIT_OVF]) && !wr_ctl && !wr_set && !control_reg[`TCLKO_BIT_OVF])
        |=> !(control_reg[`TCLKO_BIT_OVF] && !$past(wr_ctl) && !$past(wr_set) && $past(baud_mode)))
        else $error("flag set in baud mode");
    a_reload_on_ovf: assert property (@(posedge hclk) disable iff (!hresetn)
        (ovf && !cap_mode) |=> count_reg == $past(reload_reg))
        else $error("no reload at overflow");
    a_pin_toggles: assert property (@(posedge hclk) disable iff (!hresetn)
        (ovf && mode_reg[`TCLKO_BIT_CLKOE]) |=> ##1 count_in_clock_out_pin_out != $past(count_in_clock_out_pin_out))
        else $error("clock-out pin did not toggle");
    a_half_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        (src == tclko_pkg::TCLKO_SRC_OSC && tick) |=> !tick)
        else $error("count faster than half oscillator");
    a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        (!control_reg[`TCLKO_BIT_RUN] && !wr_pend_reg && !trig_fall) |=> $stable(count_reg))
        else $error("counter moved while stopped");
    a_exf_on_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        trig_fall |=> control_reg[`TCLKO_BIT_EXF])
        else $error("trigger edge lost");
    a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        control_reg[`TCLKO_BIT_EXF] |=> timer_irq)
        else $error("interrupt not requested");
    a_oe_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_reg[`TCLKO_BIT_CLKOE] |=> !count_in_clock_out_pin_oe_n)
        else $error("pin not driven in clock-out");
    a_oe_released: assert property (@(posedge hclk) disable iff (!hresetn)
        !mode_reg[`TCLKO_BIT_CLKOE] |=> count_in_clock_out_pin_oe_n)
        else $error("pin driven outside clock-out");

    // interrupt request path
    a_no_clko_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode_reg[`TCLKO_BIT_CLKOE] && !control_reg[`TCLKO_BIT_EXF]) |=> !timer_irq)
        else $error("clock-out overflow raised interrupt");
    a_irq_on_ovf: assert property (@(posedge hclk) disable iff (!hresetn)
        (control_reg[`TCLKO_BIT_OVF] && !mode_reg[`TCLKO_BIT_CLKOE]) |=> timer_irq)
        else $error("overflow flag did not interrupt");

    // flags stay until software touches the register; trigger edge seen only with its enable set
    a_ovf_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (control_reg[`TCLKO_BIT_OVF] && !wr_pend_reg) |=> control_reg[`TCLKO_BIT_OVF])
        else $error("overflow flag dropped by itself");
    a_exf_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (control_reg[`TCLKO_BIT_EXF] && !wr_pend_reg) |=> control_reg[`TCLKO_BIT_EXF])
        else $error("external flag dropped by itself");
    a_edge_gated: assert property (@(posedge hclk) disable iff (!hresetn)
        !control_reg[`TCLKO_BIT_EXEN] |-> !trig_fall)
        else $error("trigger edge seen while disabled");

    // counter stepping and reloads
    a_count_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && !ovf && !wr_pend_reg && !trig_fall) |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter did not step by one");
    a_stop_no_tick: assert property (@(posedge hclk) disable iff (!hresetn)
        !control_reg[`TCLKO_BIT_RUN] |-> !tick)
        else $error("tick while stopped");
    a_baud_reload: assert property (@(posedge hclk) disable iff (!hresetn)
        (ovf && baud_mode) |=> count_reg == $past(reload_reg))
        else $error("baud mode overflow did not reload");
    a_trig_reload: assert property (@(posedge hclk) disable iff (!hresetn)
        (trig_fall && !cap_mode && !ovf) |=> count_reg == $past(reload_reg))
        else $error("trigger edge did not reload");
    a_no_pin_src: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_reg[`TCLKO_BIT_CLKOE] |-> src != tclko_pkg::TCLKO_SRC_PIN)
        else $error("pin counted while driving clock-out");

    // clock-out pin and serial clocks
    a_pin_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> count_in_clock_out_pin_out == $past(clk_out_reg))
        else $error("pin does not carry the square wave");
    a_no_stray_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
        !(ovf && mode_reg[`TCLKO_BIT_CLKOE]) |=> $stable(clk_out_reg))
        else $error("clock-out toggled without overflow");
    a_rx_timer2: assert property (@(posedge hclk) disable iff (!hresetn)
        control_reg[`TCLKO_BIT_RXSEL] |=> rx_baud_tick == $past(ovf))
        else $error("receive clock not from timer 2");
    a_rx_timer1: assert property (@(posedge hclk) disable iff (!hresetn)
        !control_reg[`TCLKO_BIT_RXSEL] |=> rx_baud_tick == $past(timer1_overflow))
        else $error("receive clock not from timer 1");
    a_tx_timer2: assert property (@(posedge hclk) disable iff (!hresetn)
        control_reg[`TCLKO_BIT_TXSEL] |=> tx_baud_tick == $past(ovf))
        else $error("transmit clock not from timer 2");
    a_tx_timer1: assert property (@(posedge hclk) disable iff (!hresetn)
        !control_reg[`TCLKO_BIT_TXSEL] |=> tx_baud_tick == $past(timer1_overflow))
        else $error("transmit clock not from timer 1");
endmodule

// [tclko_timer_tb_top.sv]
// self-checking bench for the timer clock-out block: bus tasks plus call sequences
// assumes the design answers with zero wait states and the osc tick is every 2nd hclk
`timescale 1ns/1ps
`define TCHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end
module tclko_timer_tb_top;
    logic hclk, hresetn, hsel, hwrite, pin_in, trig, t1_ovf;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, pin_out, pin_oe_n, rx_tick, tx_tick, irq;
    wire hready_w = hreadyout;
    int errors = 0, n_tests = 0, cycles = 0, rx_cnt = 0, tx_cnt = 0, h1, h2;
    logic [7:0] q, q2;
    tclko_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_w), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .count_in_clock_out_pin_in(pin_in),
        .count_in_clock_out_pin_out(pin_out), .count_in_clock_out_pin_oe_n(pin_oe_n),
        .external_trigger_pin(trig), .timer1_overflow(t1_ovf), .rx_baud_tick(rx_tick),
        .tx_baud_tick(tx_tick), .timer_irq(irq));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic finish_test;
        if (errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // runaway guard, the sequence needs well under this
    always @(posedge hclk) begin
        cycles++;
        if (rx_tick === 1'b1) rx_cnt++;
        if (tx_tick === 1'b1) tx_cnt++;
        if (cycles > 20000) begin
            errors++;
            finish_test();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready_w !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hready_w !== 1'b1);
        r = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        bus(1'b0, a, 8'h00, r);
    endtask
    task automatic load(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    // cycles spent high and low by the clock-out pin
    task automatic halves(output int a, output int b);
        logic s;
        @(posedge hclk);
        s = pin_out;
        while (pin_out === s && a < 3000) begin @(posedge hclk); a++; end
        a = 0;
        s = pin_out;
        while (pin_out === s && a < 3000) begin @(posedge hclk); a++; end
        b = 0;
        s = pin_out;
        while (pin_out === s && b < 3000) begin @(posedge hclk); b++; end
    endtask
    initial begin
        hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h00000000; htrans = 2'h0;
        hsize = 3'h2; hwdata = 32'h00000000; pin_in = 1'b1; trig = 1'b1; t1_ovf = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'hC8, q); `TCHK(q, 8'h00)
        rd(8'hCD, q); `TCHK(q, 8'h00)
        `TCHK(pin_oe_n, 1'b1)
        `TCHK({hreadyout, hresp}, 2'b10)
        wr(8'h40, 8'h5A); rd(8'h40, q); `TCHK(q, 8'h00)
        wr(8'hD0, 8'h08); rd(8'hC8, q); `TCHK(q, 8'h08)
        wr(8'hD4, 8'h08); rd(8'hC8, q); `TCHK(q, 8'h00)
        // trigger edge ignored with edge enable off
        load(8'hCA, 16'hFFF8); load(8'hCC, 16'h1234);
        trig <= 1'b0; repeat (8) @(posedge hclk); trig <= 1'b1;
        rd(8'hCC, q); `TCHK(q, 8'h34)
        rd(8'hC8, q); `TCHK(q, 8'h00)
        wr(8'hC8, 8'h08); trig <= 1'b0; repeat (8) @(posedge hclk);
        rd(8'hC8, q); `TCHK(q, 8'h48)
        rd(8'hCC, q); `TCHK(q, 8'hF8)
        `TCHK(irq, 1'b1)
        wr(8'hC8, 8'h00); trig <= 1'b1; repeat (2) @(posedge hclk); `TCHK(irq, 1'b0)
        // oscillator count: 40 edges between read samples
        load(8'hCC, 16'h0010); wr(8'hC8, 8'h04);
        rd(8'hCC, q); repeat (37) @(posedge hclk); rd(8'hCC, q2);
        `TCHK(8'(q2 - q), 8'h14)
        // pin falling edges as count source
        wr(8'hC8, 8'h00); load(8'hCC, 16'h0000); wr(8'hC8, 8'h06);
        repeat (5) begin
            pin_in <= 1'b0; repeat (4) @(posedge hclk);
            pin_in <= 1'b1; repeat (4) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
        rd(8'hCC, q); `TCHK(q, 8'h05)
        // clock-out, start count apart from reload; oe_n lags the mode write by one edge
        wr(8'hC8, 8'h00); wr(8'hC9, 8'h02);
        repeat (2) @(posedge hclk); `TCHK(pin_oe_n, 1'b0)
        load(8'hCA, 16'hFFFE); load(8'hCC, 16'hFFF0);
        wr(8'hD0, 8'h04);
        h1 = 0; while (pin_out === 1'b0 && h1 < 100) begin @(posedge hclk); h1++; end
        `TCHK((h1 >= 28 && h1 <= 36), 1'b1)
        halves(h1, h2);
        `TCHK(h1, 2 * (65536 - 32'hFFFE))
        `TCHK(h2, h1)
        rd(8'hC8, q); `TCHK(q[7], 1'b1)
        `TCHK(irq, 1'b0)
        wr(8'hD4, 8'h04); wr(8'hC8, 8'h00); rd(8'hC8, q); `TCHK(q, 8'h00)
        // clock-out beside tx baud generation from one reload pair
        load(8'hCA, 16'hFFF8); load(8'hCC, 16'hFFF8); wr(8'hC8, 8'h14);
        halves(h1, h2);
        `TCHK(h1, 2 * (65536 - 32'hFFF8))
        `TCHK(h2, h1)
        tx_cnt = 0; rx_cnt = 0;
        repeat (160) @(posedge hclk);
        `TCHK((tx_cnt >= 9 && tx_cnt <= 11), 1'b1)
        `TCHK(rx_cnt, 0)
        t1_ovf <= 1'b1; @(posedge hclk); t1_ovf <= 1'b0; repeat (3) @(posedge hclk);
        `TCHK(rx_cnt, 1)
        rd(8'hC8, q); `TCHK(q, 8'h14)
        wr(8'hC9, 8'h00); repeat (2) @(posedge hclk); `TCHK(pin_oe_n, 1'b1)
        finish_test();
    end
endmodule
